// file: core/smipe_defines.svh
// Offsets, field positions, reset values and constants of the SMI and power event block.
// How it works
// - Pins, events, IPIs, PM events raise SMI.
// - Sleep write with trap enabled raises SMI.
// - Trapped sleep write sets status bit two.
// - Rearm write drops the line and rearms.
// - Pending enabled status makes rearm read zero.
// - Status sets regardless; disabled sources never interrupt.
// - Rearm with enabled status pending waits for resume.
// - Button override in hardware, no status bit.
// - Memory marker set by software, cleared by power loss.
// - No throttling; control reads full duty only.
// - Halt enters C1; unmasked interrupt ends it.
// - Reading the C2 entry port enters C2.
// - C2 exit undoes entry steps in reverse.
// - Interrupt, NMI, SMI, init, pending break end C2.
// - Button alone wakes S4/S5, also S3, unrecorded.
// - Alarm wakes S3 when enable bit ten set.
// - Root-port wakes need bit seventeen for S3.
// - Bit fourteen enables resume-well pin wake.
// - Bit thirteen enables external event wake.
// - Sleep request sits at control word bit thirteen.
`ifndef SMIPE_DEFINES_SVH
`define SMIPE_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices as printed and byte addresses (base + 4 * index)
// ----------------------------------------------------------------
`define SMIPE_IDX_GPE_WAKE   8'h04
`define SMIPE_IDX_SMI_EN     8'h10
`define SMIPE_IDX_SMI_STS    8'h14
`define SMIPE_IDX_MARKER     8'h2C
`define SMIPE_IDX_PM1_WAKE   8'h02
`define SMIPE_IDX_PWR_CTRL   8'h04
`define SMIPE_IDX_THROTTLE   8'h00
`define SMIPE_IDX_C2_ENTRY   8'h04
`define SMIPE_IDX_CORE_STATE 8'h08
`define SMIPE_BASE_EVENT     10'h000
`define SMIPE_BASE_POWER     10'h100
`define SMIPE_BASE_PROC      10'h200
`define SMIPE_ADDR(b, i)     ((b) + {(i), 2'b00})
`define SMIPE_ADDR_UNMAPPED  10'h3FC

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SMIPE_SRC_LGPIO      0
`define SMIPE_SRC_GPE        1
`define SMIPE_SRC_SLEEP      2
`define SMIPE_SRC_IPI        3
`define SMIPE_SRC_PM         4
`define SMIPE_NUM_SRC        5
`define SMIPE_BIT_REARM      31
`define SMIPE_BIT_SLEEP_REQ  13
`define SMIPE_SLP_TYP_LSB    10
`define SMIPE_BIT_RTC_WAKE   10
`define SMIPE_BIT_PCIE_WAKE  17
`define SMIPE_BIT_GPIO_WAKE  14
`define SMIPE_BIT_EXTERNAL_EVENT_INPUT_WAKE  13
`define SMIPE_BIT_MARKER     0

// ----------------------------------------------------------------
// Reset and fixed values
// ----------------------------------------------------------------
`define SMIPE_RST_WORD       32'h0000_0000
`define SMIPE_RST_HALF       16'h0000
`define SMIPE_THROTTLE_FULL  32'h0000_0000

`endif

// file: core/smipe_pkg.sv
// Types shared by the SMI and power event block.
package smipe_pkg;

  typedef enum logic [2:0] {
    IDLE_C0,
    IDLE_C1,
    IDLE_C2_STOP,
    IDLE_C2_GATED,
    IDLE_C2_UNGATE
  } smipe_idle_t;

  typedef struct packed {
    logic        lgpio;
    logic        gpe;
    logic        ipi;
    logic        pm;
  } smipe_src_t;

  typedef struct packed {
    logic        power_button;
    logic        rtc_alarm;
    logic        pcie_wake;
    logic        gpio_wake;
    logic        external_event_input;
  } smipe_wake_src_t;

  typedef struct packed {
    logic        irq_unmasked_active;
    logic        nmi_internal;
    logic        init_request;
    logic        pending_break_indication_n;
  } smipe_break_t;

endpackage

// file: core/smipe_top.sv
// SMI generation, sleep trap, idle states and wake logic behind an AHB-Lite slave.
`include "smipe_defines.svh"

module smipe_top (
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  // AHB-Lite slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic      [31:0]            hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  // Event sources and core status
  input  wire smipe_pkg::smipe_src_t  smi_src,
  input  wire logic                   resume_exec,
  input  wire logic                   halt_instruction,
  input  wire smipe_pkg::smipe_break_t brk,
  // Sleep and wake
  input  wire logic                   in_s3,
  input  wire logic                   in_s45,
  input  wire smipe_pkg::smipe_wake_src_t wake_src,
  input  wire logic                   button_override_req,
  input  wire logic                   power_lost,
  // Core and power sequencer outputs
  output logic                        management_irq_line,
  output logic                        core_halted,
  output logic                        core_stop_req,
  output logic                        core_clk_gate,
  output logic                        sleep_go,
  output logic      [2:0]             sleep_type,
  output logic                        wake_req,
  output logic                        force_off
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0]                      hrdata;
    logic                             hready;
    logic                             rd_pend;
    logic                             wr_pend;
    logic [9:0]                       addr;
    logic [31:0]                      smi_en;
    logic [`SMIPE_NUM_SRC-1:0]        smi_sts;
    logic                             armed;
    logic                             rearm_wait;
    logic                             smi_line;
    logic [31:0]                      gpe_wake_en;
    logic [15:0]                      pm1_wake_en;
    logic [2:0]                       slp_typ;
    logic                             sleep_go;
    logic                             marker;
    smipe_pkg::smipe_idle_t           idle;
    logic                             core_halt;
    logic                             core_stop;
    logic                             clk_gate;
    logic                             wake;
    logic                             force_off;
  } smipe_state_t;

  localparam logic [9:0] A_GPE_WAKE = `SMIPE_ADDR(`SMIPE_BASE_EVENT, `SMIPE_IDX_GPE_WAKE);
  localparam logic [9:0] A_SMI_EN   = `SMIPE_ADDR(`SMIPE_BASE_EVENT, `SMIPE_IDX_SMI_EN);
  localparam logic [9:0] A_SMI_STS  = `SMIPE_ADDR(`SMIPE_BASE_EVENT, `SMIPE_IDX_SMI_STS);
  localparam logic [9:0] A_MARKER   = `SMIPE_ADDR(`SMIPE_BASE_EVENT, `SMIPE_IDX_MARKER);
  localparam logic [9:0] A_PM1_WAKE = `SMIPE_ADDR(`SMIPE_BASE_POWER, `SMIPE_IDX_PM1_WAKE);
  localparam logic [9:0] A_PWR_CTRL = `SMIPE_ADDR(`SMIPE_BASE_POWER, `SMIPE_IDX_PWR_CTRL);
  localparam logic [9:0] A_THROTTLE = `SMIPE_ADDR(`SMIPE_BASE_PROC, `SMIPE_IDX_THROTTLE);
  localparam logic [9:0] A_C2_ENTRY = `SMIPE_ADDR(`SMIPE_BASE_PROC, `SMIPE_IDX_C2_ENTRY);
  localparam logic [9:0] A_CORE     = `SMIPE_ADDR(`SMIPE_BASE_PROC, `SMIPE_IDX_CORE_STATE);

  smipe_state_t q;
  smipe_state_t d;
  smipe_state_t rst_val;

  logic                               acc;
  logic                               wr_sts;
  logic                               rearm_wr;
  logic                               slp_wr;
  logic                               trap;
  logic                               pend;
  logic                               brk_c2;
  logic [`SMIPE_NUM_SRC-1:0]          set_v;
  logic [`SMIPE_NUM_SRC-1:0]          clr_v;
  logic [31:0]                        rd_val;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.sleep_go = 1'b0;
    d.wake = 1'b0;
    d.wr_pend = 1'b0;
    acc = hsel && htrans[1] && hready;
    wr_sts = q.wr_pend && (q.addr == A_SMI_STS);
    rearm_wr = wr_sts && hwdata[`SMIPE_BIT_REARM];
    slp_wr = q.wr_pend && (q.addr == A_PWR_CTRL) && hwdata[`SMIPE_BIT_SLEEP_REQ];
    trap = slp_wr && q.smi_en[`SMIPE_SRC_SLEEP];
    pend = |(q.smi_sts & q.smi_en[`SMIPE_NUM_SRC-1:0]);

    // Every source latches its status bit, enabled or not; a set in the clear cycle wins.
    set_v = {smi_src.pm, smi_src.ipi, slp_wr, smi_src.gpe, smi_src.lgpio};
    clr_v = wr_sts ? hwdata[`SMIPE_NUM_SRC-1:0] : '0;
    d.smi_sts = (q.smi_sts & ~clr_v) | set_v;

    // A trapped sleep request is withheld; firmware repeats it with the trap disabled.
    d.sleep_go = slp_wr && !q.smi_en[`SMIPE_SRC_SLEEP];

    // Register writes land in the data phase.
    if (q.wr_pend) begin
      unique case (q.addr)
        A_GPE_WAKE: d.gpe_wake_en = hwdata;
        A_SMI_EN:   d.smi_en = hwdata;
        A_PM1_WAKE: d.pm1_wake_en = hwdata[15:0];
        A_PWR_CTRL: d.slp_typ = hwdata[`SMIPE_SLP_TYP_LSB+2:`SMIPE_SLP_TYP_LSB];
        default:    d.slp_typ = q.slp_typ;
      endcase
    end

    // Marker only sets from software; power loss is its only clear.
    if (q.wr_pend && (q.addr == A_MARKER) && hwdata[`SMIPE_BIT_MARKER]) begin
      d.marker = 1'b1;
    end
    if (power_lost) begin
      d.marker = 1'b0;
    end

    // SMI arming: one request per handler, ended by the rearm write.
    if (rearm_wr) begin
      d.smi_line = 1'b0;
      if (pend) begin
        d.armed = 1'b0;
        d.rearm_wait = 1'b1;
      end else begin
        d.armed = 1'b1;
        d.rearm_wait = 1'b0;
      end
    end else if (q.rearm_wait && resume_exec) begin
      d.rearm_wait = 1'b0;
      d.armed = 1'b1;
    end else if (q.armed && pend) begin
      d.smi_line = 1'b1;
      d.armed = 1'b0;
    end

    // Bus: reads take one wait state so read data comes from a flop.
    if (q.rd_pend) begin
      d.hrdata = rd_val;
      d.hready = 1'b1;
      d.rd_pend = 1'b0;
    end else if (acc) begin
      d.addr = (|haddr[31:10]) ? `SMIPE_ADDR_UNMAPPED : haddr[9:0];
      d.wr_pend = hwrite;
      d.rd_pend = !hwrite;
      d.hready = hwrite;
    end

    // Idle states; entry and exit steps mirror each other.
    brk_c2 = brk.irq_unmasked_active || brk.nmi_internal || q.smi_line
             || brk.init_request || !brk.pending_break_indication_n;
    unique case (q.idle)
      smipe_pkg::IDLE_C0: begin
        if (acc && !hwrite && (haddr[9:0] == A_C2_ENTRY) && !(|haddr[31:10])) begin
          d.idle = smipe_pkg::IDLE_C2_STOP;
          d.core_stop = 1'b1;
        end else if (halt_instruction) begin
          d.idle = smipe_pkg::IDLE_C1;
          d.core_halt = 1'b1;
        end
      end
      smipe_pkg::IDLE_C1: begin
        if (brk.irq_unmasked_active) begin
          d.idle = smipe_pkg::IDLE_C0;
          d.core_halt = 1'b0;
        end
      end
      smipe_pkg::IDLE_C2_STOP: begin
        d.idle = smipe_pkg::IDLE_C2_GATED;
        d.clk_gate = 1'b1;
      end
      smipe_pkg::IDLE_C2_GATED: begin
        if (brk_c2) begin
          d.idle = smipe_pkg::IDLE_C2_UNGATE;
          d.clk_gate = 1'b0;
        end
      end
      smipe_pkg::IDLE_C2_UNGATE: begin
        d.idle = smipe_pkg::IDLE_C0;
        d.core_stop = 1'b0;
      end
    endcase

    // Wake: the button alone leaves S4/S5 and leaves no trace in any status register.
    if (in_s45) begin
      d.wake = wake_src.power_button;
    end else if (in_s3) begin
      d.wake = wake_src.power_button
               || (wake_src.rtc_alarm && q.pm1_wake_en[`SMIPE_BIT_RTC_WAKE])
               || (wake_src.pcie_wake && q.gpe_wake_en[`SMIPE_BIT_PCIE_WAKE])
               || (wake_src.gpio_wake && q.gpe_wake_en[`SMIPE_BIT_GPIO_WAKE])
               || (wake_src.external_event_input
                   && q.gpe_wake_en[`SMIPE_BIT_EXTERNAL_EVENT_INPUT_WAKE]);
    end

    // Override acts in hardware only and is not recorded.
    d.force_off = button_override_req;
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    unique case (q.addr)
      A_GPE_WAKE: rd_val = q.gpe_wake_en;
      A_SMI_EN:   rd_val = q.smi_en;
      A_SMI_STS:  rd_val = {q.armed, 26'h0, q.smi_sts};
      A_MARKER:   rd_val = {31'h0, q.marker};
      A_PM1_WAKE: rd_val = {16'h0, q.pm1_wake_en};
      A_PWR_CTRL: rd_val = {18'h0, 1'b0, q.slp_typ, 10'h0};
      A_THROTTLE: rd_val = `SMIPE_THROTTLE_FULL;
      A_CORE:     rd_val = {29'h0, q.idle};
      default:    rd_val = 32'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_comb begin
    rst_val = '0;
    rst_val.hready = 1'b1;
    rst_val.armed = 1'b1;
    rst_val.smi_en = `SMIPE_RST_WORD;
    rst_val.gpe_wake_en = `SMIPE_RST_WORD;
    rst_val.pm1_wake_en = `SMIPE_RST_HALF;
    rst_val.idle = smipe_pkg::IDLE_C0;
    // The marker lives in the power-loss domain, so a resume-well reset keeps it.
    rst_val.marker = q.marker && !power_lost;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= rst_val;
    end else begin
      q <= d;
    end
  end

  assign hrdata = q.hrdata;
  assign hreadyout = q.hready;
  assign hresp = 1'b0;
  assign management_irq_line = q.smi_line;
  assign core_halted = q.core_halt;
  assign core_stop_req = q.core_stop;
  assign core_clk_gate = q.clk_gate;
  assign sleep_go = q.sleep_go;
  assign sleep_type = q.slp_typ;
  assign wake_req = q.wake;
  assign force_off = q.force_off;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_trap_sets_status;
    trap |=> q.smi_sts[`SMIPE_SRC_SLEEP];
  endproperty
  a_trap_sets_status: assert property (p_trap_sets_status)
    else $error("trapped sleep write did not set status");

  property p_trap_withholds_sleep;
    slp_wr |=> (q.sleep_go != $past(q.smi_en[`SMIPE_SRC_SLEEP]));
  endproperty
  a_trap_withholds_sleep: assert property (p_trap_withholds_sleep)
    else $error("sleep request passed or withheld wrongly");

  property p_rearm_drops_line;
    rearm_wr |=> !q.smi_line ##0 (q.armed != q.rearm_wait);
  endproperty
  a_rearm_drops_line: assert property (p_rearm_drops_line)
    else $error("rearm write left line high or arming wrong");

  property p_pending_rearm_waits;
    rearm_wr && pend |=> !q.armed && q.rearm_wait && !q.smi_line;
  endproperty
  a_pending_rearm_waits: assert property (p_pending_rearm_waits)
    else $error("rearm completed with enabled status pending");

  property p_fire_after_resume;
    q.rearm_wait && resume_exec && !rearm_wr && pend && !wr_sts |=> ##1 q.smi_line;
  endproperty
  a_fire_after_resume: assert property (p_fire_after_resume)
    else $error("no request after resume with pending status");

  property p_status_unconditional;
    smi_src.lgpio |=> q.smi_sts[`SMIPE_SRC_LGPIO];
  endproperty
  a_status_unconditional: assert property (p_status_unconditional)
    else $error("disabled source did not record status");

  property p_line_needs_enable;
    $rose(q.smi_line) |-> $past(pend);
  endproperty
  a_line_needs_enable: assert property (p_line_needs_enable)
    else $error("request raised without an enabled status");

  sequence s_c2_in;
    q.core_stop && !q.clk_gate ##1 q.core_stop && q.clk_gate;
  endsequence

  property p_c2_entry;
    acc && !hwrite && (haddr == {22'h0, A_C2_ENTRY}) && (q.idle == smipe_pkg::IDLE_C0)
      |=> s_c2_in;
  endproperty
  a_c2_entry: assert property (p_c2_entry)
    else $error("C2 entry port read did not enter C2");

  property p_c2_exit_order;
    $fell(q.clk_gate) |-> q.core_stop ##1 !q.core_stop;
  endproperty
  a_c2_exit_order: assert property (p_c2_exit_order)
    else $error("C2 exit steps out of order");

  property p_throttle_full;
    q.rd_pend && (q.addr == A_THROTTLE) |=> (q.hrdata == `SMIPE_THROTTLE_FULL) && q.hready;
  endproperty
  a_throttle_full: assert property (p_throttle_full)
    else $error("throttle control read not full duty");

  property p_deep_wake_button_only;
    in_s45 && !wake_src.power_button |=> !q.wake;
  endproperty
  a_deep_wake_button_only: assert property (p_deep_wake_button_only)
    else $error("wake from S4/S5 without the button");

endmodule

// file: verif/smipe_core_model.sv
// Behavioural model of the processor core and its handler facing the event block.
module smipe_core_model (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // Commands from the bench
  input  wire logic [3:0]            src_cmd,
  input  wire logic                  halt_cmd,
  input  wire logic                  resume_cmd,
  // Block side
  input  wire logic                  management_irq_line,
  output smipe_pkg::smipe_src_t      smi_src,
  output logic                       halt_instruction,
  output logic                       resume_exec
);
  timeunit 1ns;
  timeprecision 1ps;

  logic in_smm_q;

  // The core can only run its resume instruction from inside the handler.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      smi_src          <= 4'h0;
      halt_instruction <= 1'b0;
      resume_exec      <= 1'b0;
      in_smm_q         <= 1'b0;
    end else begin
      smi_src          <= src_cmd; // Events last one cycle, so a source is gone before clearing.
      halt_instruction <= halt_cmd;
      resume_exec      <= resume_cmd & in_smm_q;
      in_smm_q         <= (in_smm_q | management_irq_line) & ~(resume_cmd & in_smm_q);
    end
  end
endmodule

// file: verif/smipe_tb.sv
// Self-checking testbench of the SMI and power event block.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  typedef struct {logic [31:0] a; logic [31:0] w; logic [31:0] e;} smipe_row_t;
  localparam logic [31:0] A_WAKE = 32'h0000_0010;
  localparam logic [31:0] A_EN   = 32'h0000_0040;
  localparam logic [31:0] A_STS  = 32'h0000_0050;
  localparam logic [31:0] A_MRK  = 32'h0000_00B0;
  localparam logic [31:0] A_PM1  = 32'h0000_0108;
  localparam logic [31:0] A_PWR  = 32'h0000_0110;
  localparam logic [31:0] A_C2   = 32'h0000_0210;
  localparam logic [31:0] ARM    = 32'h8000_0000;
  logic                        ref_clk = 1'b0;
  logic                        rst = 1'b1;
  logic                        hsel = 1'b0;
  logic                        hwrite = 1'b0;
  logic [1:0]                  htrans = 2'h0;
  logic [31:0]                 haddr = 32'h0000_0000;
  logic [31:0]                 hwdata = 32'h0000_0000;
  logic [31:0]                 hrdata;
  logic [31:0]                 rd;
  logic [31:0]                 sleeps = 32'h0000_0000;
  logic                        hready, hreadyout, hresp;
  logic [3:0]                  src_cmd = 4'h0;
  logic                        halt_cmd = 1'b0;
  logic                        resume_cmd = 1'b0;
  smipe_pkg::smipe_src_t       smi_src;
  logic                        halt_instruction, resume_exec;
  smipe_pkg::smipe_break_t     brk = 4'h1;
  smipe_pkg::smipe_wake_src_t  wake_src = 5'h00;
  logic                        in_s3 = 1'b0;
  logic                        in_s45 = 1'b0;
  logic                        button_override_req = 1'b0;
  logic                        power_lost = 1'b1;
  logic                        management_irq_line, core_halted, core_stop_req, core_clk_gate;
  logic                        sleep_go, wake_req, force_off;
  logic [2:0]                  sleep_type;
  int                          num_errors = 0;
  int                          cmp_count = 0;
  smipe_row_t rows[6] = '{'{A_WAKE, 32'hFFFF_FFFF, 32'hFFFF_FFFF},
    '{A_PM1, 32'hFFFF_FFFF, 32'h0000_FFFF}, '{A_EN, 32'h0000_001F, 32'h0000_001F},
    '{A_PWR, 32'h0000_1C00, 32'h0000_1C00}, '{32'h0000_0200, 32'hFFFF_FFFF, 32'h0000_0000},
    '{32'h0000_03FC, 32'hFFFF_FFFF, 32'h0000_0000}};
  logic [3:0]  scmd[4] = '{4'h8, 4'h4, 4'h2, 4'h1};
  logic [31:0] sbit[4] = '{32'h0000_0001, 32'h0000_0002, 32'h0000_0008, 32'h0000_0010};
  logic [3:0]  bv[4] = '{4'h9, 4'h5, 4'h3, 4'h0};

  assign hready = hreadyout;
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (sleep_go === 1'b1) sleeps <= sleeps + 32'h0000_0001;

  smipe_top uut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .smi_src(smi_src), .resume_exec(resume_exec),
    .halt_instruction(halt_instruction), .brk(brk), .in_s3(in_s3), .in_s45(in_s45),
    .wake_src(wake_src), .button_override_req(button_override_req), .power_lost(power_lost),
    .management_irq_line(management_irq_line), .core_halted(core_halted),
    .core_stop_req(core_stop_req), .core_clk_gate(core_clk_gate), .sleep_go(sleep_go),
    .sleep_type(sleep_type), .wake_req(wake_req), .force_off(force_off));

  smipe_core_model core (.ref_clk(ref_clk), .rst(rst), .src_cmd(src_cmd), .halt_cmd(halt_cmd),
    .resume_cmd(resume_cmd), .management_irq_line(management_irq_line), .smi_src(smi_src),
    .halt_instruction(halt_instruction), .resume_exec(resume_exec));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string m);
    chk32({31'h0, got}, {31'h0, exp}, m);
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return management_irq_line;
      1: return core_halted;
      2: return core_clk_gate;
      default: return core_stop_req;
    endcase
  endfunction

  // Bounded wait on one output; a hang ends the run as a mismatch.
  task automatic await(input int s, input logic v);
    int n;
    n = 0;
    while (pick(s) !== v && n < 40) begin
      @(posedge ref_clk);
      n++;
    end
    if (pick(s) !== v) begin
      num_errors++;
      $display("wrong value at %0t: output %0d never reached %b", $time, s, v);
      give_verdict();
    end
  endtask

  task automatic bus_wait;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      num_errors++;
      $display("wrong value at %0t: bus hang", $time);
      give_verdict();
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge ref_clk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    bus_wait();
    htrans <= 2'h0;
    hwdata <= d;
    bus_wait();
    q = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [31:0] e, input string m);
    bus(1'b0, a, 32'h0000_0000, rd);
    chk32(rd, e, m);
  endtask

  task automatic pulse_src(input logic [3:0] b);
    @(posedge ref_clk);
    src_cmd <= b;
    @(posedge ref_clk);
    src_cmd <= 4'h0;
  endtask

  // Bit 4 is the button, then alarm, root ports, pins and external event.
  task automatic wake_chk(input logic [4:0] exp);
    for (int i = 0; i < 5; i++) begin
      @(posedge ref_clk);
      wake_src <= 5'h01 << i;
      repeat (3) @(posedge ref_clk);
      chk1(wake_req, exp[i], "wake");
      wake_src <= 5'h00;
      repeat (3) @(posedge ref_clk);
    end
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk);
    rst        <= 1'b0;
    power_lost <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rdchk(rows[i].a, rows[i].e, "register");
    end
    chk1(hresp, 1'b0, "response");
    $display("test registers finished");
    wr(A_MRK, 32'h0000_0001);
    wr(A_MRK, 32'h0000_0000);
    rdchk(A_MRK, 32'h0000_0001, "marker held");
    @(posedge ref_clk);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    rdchk(A_EN, 32'h0000_0000, "enable reset");
    rdchk(A_STS, ARM, "status reset");
    rdchk(A_MRK, 32'h0000_0001, "marker kept");
    @(posedge ref_clk);
    power_lost <= 1'b1;
    @(posedge ref_clk);
    power_lost <= 1'b0;
    rdchk(A_MRK, 32'h0000_0000, "marker lost");
    $display("test reset finished");
    wr(A_EN, 32'h0000_001B);
    for (int i = 0; i < 4; i++) begin
      pulse_src(scmd[i]);
      await(0, 1'b1);
      rdchk(A_STS, sbit[i], "source status");
      wr(A_STS, sbit[i]);
      wr(A_STS, ARM);
      await(0, 1'b0);
      rdchk(A_STS, ARM, "rearmed");
    end
    wr(A_EN, 32'h0000_0000);
    pulse_src(4'h4);
    repeat (6) @(posedge ref_clk);
    chk1(management_irq_line, 1'b0, "disabled source");
    rdchk(A_STS, 32'h8000_0002, "disabled status");
    wr(A_STS, 32'h0000_0002);
    $display("test sources finished");
    wr(A_EN, 32'h0000_0002);
    pulse_src(4'h4);
    await(0, 1'b1);
    wr(A_STS, ARM);
    await(0, 1'b0);
    rdchk(A_STS, 32'h0000_0002, "rearm pending");
    repeat (4) @(posedge ref_clk);
    chk1(management_irq_line, 1'b0, "held rearm");
    @(posedge ref_clk);
    resume_cmd <= 1'b1;
    @(posedge ref_clk);
    resume_cmd <= 1'b0;
    await(0, 1'b1);
    wr(A_STS, 32'h0000_0002);
    wr(A_STS, ARM);
    await(0, 1'b0);
    $display("test pending rearm finished");
    wr(A_EN, 32'h0000_0004);
    wr(A_PWR, 32'h0000_2000);
    await(0, 1'b1);
    rdchk(A_STS, 32'h0000_0004, "sleep status");
    chk32(sleeps, 32'h0000_0000, "trapped sleep");
    wr(A_STS, 32'h0000_0004);
    wr(A_STS, ARM);
    await(0, 1'b0);
    wr(A_EN, 32'h0000_0000);
    wr(A_PWR, 32'h0000_2C00);
    repeat (3) @(posedge ref_clk);
    chk32(sleeps, 32'h0000_0001, "sleep pulse");
    chk32(32'(sleep_type), 32'h0000_0003, "sleep type");
    rdchk(A_PWR, 32'h0000_0C00, "control word");
    rdchk(A_STS, 32'h8000_0004, "untrapped status");
    $display("test sleep finished");
    @(posedge ref_clk);
    halt_cmd <= 1'b1;
    @(posedge ref_clk);
    halt_cmd <= 1'b0;
    await(1, 1'b1);
    brk <= 4'h9;
    await(1, 1'b0);
    brk <= 4'h1;
    for (int k = 0; k < 4; k++) begin
      bus(1'b0, A_C2, 32'h0000_0000, rd);
      chk32(rd, 32'h0000_0000, "entry port");
      chk1(core_clk_gate, 1'b1, "clock gated");
      rdchk(32'h0000_0220, {29'h0, smipe_pkg::IDLE_C2_GATED}, "core state");
      @(posedge ref_clk);
      brk <= bv[k];
      await(2, 1'b0);
      chk1(core_stop_req, 1'b1, "exit order");
      await(3, 1'b0);
      brk <= 4'h1;
    end
    wr(A_EN, 32'h0000_0002);
    bus(1'b0, A_C2, 32'h0000_0000, rd);
    pulse_src(4'h4);
    await(3, 1'b0);
    chk1(management_irq_line, 1'b1, "smi break");
    wr(A_STS, 32'h0000_0002);
    wr(A_STS, ARM);
    wr(A_EN, 32'h0000_0000);
    $display("test idle finished");
    in_s3 <= 1'b1;
    wr(A_WAKE, 32'h0002_6000);
    wr(A_PM1, 32'h0000_0400);
    wake_chk(5'h1F);
    wr(A_WAKE, 32'h0000_0000);
    wr(A_PM1, 32'h0000_0000);
    wake_chk(5'h10);
    wr(A_WAKE, 32'h0002_6000);
    wr(A_PM1, 32'h0000_0400);
    in_s45 <= 1'b1;
    wake_chk(5'h10);
    $display("test wake finished");
    wr(A_STS, 32'h0000_001F);
    button_override_req <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk1(force_off, 1'b1, "override");
    button_override_req <= 1'b0;
    rdchk(A_STS, ARM, "no override status");
    $display("test override finished");
    give_verdict();
  end
endmodule
